/* sbt_tap_front.sv */
`timescale 1ns/100ps
`default_nettype none
module sbt_tap_front #(
   parameter int BSR_W = sbt_pkg::BSR_W,
   parameter logic [sbt_pkg::ID_W-1:0] ID_CODE = sbt_pkg::ID_CODE_VAL
) (
   // system side
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [BSR_W-1:0] i_ring,
   output logic o_mem_hiz,
   // test link
   input wire logic i_tck_link,
   input wire sbt_pkg::sbt_pins_s i_tap,
   output logic o_tdo,
   output logic o_tdo_oe
);

   function automatic sbt_pkg::sbt_sel_e dr_sel(input logic [sbt_pkg::IR_W-1:0] ins);
      sbt_pkg::sbt_sel_e s;
      s = sbt_pkg::SEL_BYP;
      case (ins)
         sbt_pkg::INS_EXTEST, sbt_pkg::INS_SAMPLE, sbt_pkg::INS_SAMPLEZ: s = sbt_pkg::SEL_BSR;
         sbt_pkg::INS_IDCODE: s = sbt_pkg::SEL_ID;
         default: s = sbt_pkg::SEL_BYP;
      endcase
      return s;
   endfunction : dr_sel

   sbt_pkg::sbt_state_e state_r, state_nxt;
   logic rst_t1, rst_t2, ce_t1, ce_t2, en_t;
   logic [BSR_W-1:0] ring_r, ring_t1, ring_t2, bsr_r;
   logic [sbt_pkg::ID_W-1:0] id_r;
   logic byp_r;
   logic [sbt_pkg::IR_W-1:0] ir_r, ir_sr_r, ir_nxt;
   logic tms, tdi, sel_lsb, hiz_t_r, hiz_s1;
   sbt_pkg::sbt_sel_e sel;

   // pull-ups on the pads: an undriven pin reads high
   assign tms = i_tap.tms_en ? i_tap.tms : 1'b1;
   assign tdi = i_tap.tdi_en ? i_tap.tdi : 1'b1;
   assign sel = dr_sel(ir_r);
   assign en_t = ce_t2;

   // system domain: ring snapshot source and high-z request
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ring_r <= '0;
      end else if (i_ce) begin
         ring_r <= i_ring;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         hiz_s1 <= 1'b0;
         o_mem_hiz <= 1'b0;
      end else if (i_ce) begin
         hiz_s1 <= hiz_t_r;
         o_mem_hiz <= hiz_s1;
      end
   end

   // link reset asserts at once, so a parked test clock still leaves the port in reset
   always_ff @(posedge i_tck_link or posedge i_rst) begin
      if (i_rst) begin
         rst_t1 <= 1'b1;
         rst_t2 <= 1'b1;
      end else begin
         rst_t1 <= 1'b0;
         rst_t2 <= rst_t1;
      end
   end

   // link domain synchronisers; the ring bits may be caught mid-change, which is harmless
   always_ff @(posedge i_tck_link) begin
      ce_t1 <= i_ce;
      ce_t2 <= ce_t1;
      ring_t1 <= ring_r;
      ring_t2 <= ring_t1;
   end

   // controller
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         sbt_pkg::ST_TLR: state_nxt = tms ? sbt_pkg::ST_TLR : sbt_pkg::ST_IDLE;
         sbt_pkg::ST_IDLE: state_nxt = tms ? sbt_pkg::ST_SELDR : sbt_pkg::ST_IDLE;
         sbt_pkg::ST_SELDR: state_nxt = tms ? sbt_pkg::ST_SELIR : sbt_pkg::ST_CAPDR;
         sbt_pkg::ST_CAPDR: state_nxt = tms ? sbt_pkg::ST_EX1DR : sbt_pkg::ST_SHDR;
         sbt_pkg::ST_SHDR: state_nxt = tms ? sbt_pkg::ST_EX1DR : sbt_pkg::ST_SHDR;
         sbt_pkg::ST_EX1DR: state_nxt = tms ? sbt_pkg::ST_UPDR : sbt_pkg::ST_PAUDR;
         sbt_pkg::ST_PAUDR: state_nxt = tms ? sbt_pkg::ST_EX2DR : sbt_pkg::ST_PAUDR;
         sbt_pkg::ST_EX2DR: state_nxt = tms ? sbt_pkg::ST_UPDR : sbt_pkg::ST_SHDR;
         sbt_pkg::ST_UPDR: state_nxt = tms ? sbt_pkg::ST_SELDR : sbt_pkg::ST_IDLE;
         sbt_pkg::ST_SELIR: state_nxt = tms ? sbt_pkg::ST_TLR : sbt_pkg::ST_CAPIR;
         sbt_pkg::ST_CAPIR: state_nxt = tms ? sbt_pkg::ST_EX1IR : sbt_pkg::ST_SHIR;
         sbt_pkg::ST_SHIR: state_nxt = tms ? sbt_pkg::ST_EX1IR : sbt_pkg::ST_SHIR;
         sbt_pkg::ST_EX1IR: state_nxt = tms ? sbt_pkg::ST_UPIR : sbt_pkg::ST_PAUIR;
         sbt_pkg::ST_PAUIR: state_nxt = tms ? sbt_pkg::ST_EX2IR : sbt_pkg::ST_PAUIR;
         sbt_pkg::ST_EX2IR: state_nxt = tms ? sbt_pkg::ST_UPIR : sbt_pkg::ST_SHIR;
         sbt_pkg::ST_UPIR: state_nxt = tms ? sbt_pkg::ST_SELDR : sbt_pkg::ST_IDLE;
         default: state_nxt = sbt_pkg::ST_TLR;
      endcase
   end

   always_ff @(posedge i_tck_link or posedge rst_t2) begin
      if (rst_t2) begin
         state_r <= sbt_pkg::ST_TLR;
      end else if (en_t) begin
         state_r <= state_nxt;
      end
   end

   // instruction register
   always_ff @(posedge i_tck_link or posedge rst_t2) begin
      if (rst_t2) begin
         ir_r <= sbt_pkg::IR_RESET_VAL;
         ir_sr_r <= sbt_pkg::IR_RESET_VAL;
      end else if (en_t) begin
         case (state_r)
            sbt_pkg::ST_TLR: ir_r <= sbt_pkg::IR_RESET_VAL;
            sbt_pkg::ST_CAPIR: ir_sr_r <= {1'b0, sbt_pkg::IR_CAPTURE_PAT};
            sbt_pkg::ST_SHIR: ir_sr_r <= {tdi, ir_sr_r[sbt_pkg::IR_W-1:1]};
            sbt_pkg::ST_UPIR: ir_r <= ir_sr_r;
            default: ir_r <= ir_r;
         endcase
      end
   end

   // data registers; update-dr does nothing since preload is absent
   always_ff @(posedge i_tck_link or posedge rst_t2) begin
      if (rst_t2) begin
         bsr_r <= '0;
         id_r <= '0;
         byp_r <= sbt_pkg::BYP_CAPTURE_VAL;
      end else if (en_t && state_r == sbt_pkg::ST_CAPDR) begin
         case (sel)
            sbt_pkg::SEL_BSR: bsr_r <= ring_t2;
            sbt_pkg::SEL_ID: id_r <= ID_CODE;
            default: byp_r <= sbt_pkg::BYP_CAPTURE_VAL;
         endcase
      end else if (en_t && state_r == sbt_pkg::ST_SHDR) begin
         case (sel)
            sbt_pkg::SEL_BSR: bsr_r <= {tdi, bsr_r[BSR_W-1:1]};
            sbt_pkg::SEL_ID: id_r <= {tdi, id_r[sbt_pkg::ID_W-1:1]};
            default: byp_r <= tdi;
         endcase
      end
   end

   // instruction as it will stand after this edge
   always_comb begin
      ir_nxt = ir_r;
      if (state_r == sbt_pkg::ST_TLR) begin
         ir_nxt = sbt_pkg::IR_RESET_VAL;
      end else if (state_r == sbt_pkg::ST_UPIR) begin
         ir_nxt = ir_sr_r;
      end
   end

   // high-z request follows the new instruction on the same edge, as the test clock may
   // stop right after update; never raised while in reset
   always_ff @(posedge i_tck_link or posedge rst_t2) begin
      if (rst_t2) begin
         hiz_t_r <= 1'b0;
      end else if (en_t) begin
         hiz_t_r <= (ir_nxt == sbt_pkg::INS_SAMPLEZ) && (state_nxt != sbt_pkg::ST_TLR);
      end
   end

   always_comb begin
      case (sel)
         sbt_pkg::SEL_BSR: sel_lsb = bsr_r[0];
         sbt_pkg::SEL_ID: sel_lsb = id_r[0];
         default: sel_lsb = byp_r;
      endcase
      if (state_r == sbt_pkg::ST_SHIR) begin
         sel_lsb = ir_sr_r[0];
      end
   end

   // output launched on the falling edge to give the receiver half a period of setup
   always_ff @(negedge i_tck_link or posedge rst_t2) begin
      if (rst_t2) begin
         o_tdo <= 1'b0;
         o_tdo_oe <= 1'b0;
      end else if (en_t) begin
         o_tdo <= sel_lsb;
         o_tdo_oe <= (state_r == sbt_pkg::ST_SHDR) || (state_r == sbt_pkg::ST_SHIR);
      end
   end

   sequence tms_high_run;
      (tms && en_t) [*5];
   endsequence

   chk_tms_five_reset: assert property (@(posedge i_tck_link) disable iff (rst_t2)
      tms_high_run |=> state_r == sbt_pkg::ST_TLR)
      else $error("five tms highs did not reset the controller");

   chk_ir_reset_load: assert property (@(posedge i_tck_link) disable iff (rst_t2)
      (state_r == sbt_pkg::ST_TLR && en_t) |=> ir_r == sbt_pkg::INS_IDCODE)
      else $error("instruction not idcode after reset state");

   chk_capture_ir_pat: assert property (@(posedge i_tck_link) disable iff (rst_t2)
      (state_r == sbt_pkg::ST_CAPIR && en_t) |=> ir_sr_r[1:0] == 2'h1)
      else $error("instruction capture pattern wrong");

   chk_shift_msb_in: assert property (@(posedge i_tck_link) disable iff (rst_t2)
      (state_r == sbt_pkg::ST_SHIR && en_t) |=> ir_sr_r[2] == $past(tdi))
      else $error("data-in did not enter the top bit");

   chk_bypass_path: assert property (@(posedge i_tck_link) disable iff (rst_t2)
      (state_r == sbt_pkg::ST_CAPDR && sel == sbt_pkg::SEL_BYP && en_t)
      |=> (sel_lsb == 1'b0) ##1
      (state_r != sbt_pkg::ST_SHDR || !$past(en_t) || sel_lsb == $past(tdi)))
      else $error("bypass path not selected");

   chk_tdo_oe_shift: assert property (@(negedge i_tck_link) disable iff (rst_t2)
      $rose(o_tdo_oe) |->
      ($past(state_r) == sbt_pkg::ST_SHDR || $past(state_r) == sbt_pkg::ST_SHIR))
      else $error("data-out enabled outside a shift state");

   chk_pullup_tms: assert property (@(posedge i_tck_link) disable iff (rst_t2)
      (!i_tap.tms_en && state_r == sbt_pkg::ST_IDLE && en_t) |=> state_r == sbt_pkg::ST_SELDR)
      else $error("undriven mode-select not seen as high");

   chk_reset_no_hiz: assert property (@(posedge i_tck_link) disable iff (rst_t2)
      (state_r == sbt_pkg::ST_TLR && en_t) |=> !hiz_t_r)
      else $error("memory disturbed while in reset state");

   chk_tdo_from_lsb: assert property (@(negedge i_tck_link) disable iff (rst_t2)
      (en_t && state_r == sbt_pkg::ST_SHDR && $stable(state_r)) |=> o_tdo == $past(sel_lsb))
      else $error("data-out not the selected low bit");

endmodule : sbt_tap_front
`default_nettype wire

/* sbt_pkg.sv */
// How it works
// - every test input is sampled on the rising test clock and every test output is launched on the falling one.
// - the controller moves on the mode-select level seen at each rising test clock, so the controller outside sets it up before that edge.
// - an undriven mode-select or data-in pin reads as logic high.
// - exactly one register sits between data-in and data-out, chosen by the held instruction.
// - serial bits enter the selected register at its top bit and shift toward bit zero.
// - after power-up the port sits in its reset state and leaves the memory alone.
// - the port has a controller plus instruction, boundary, one-bit bypass and identification registers.
// - data-out carries the low bit of the selected register and changes on the falling test clock.
// - five rising test clocks with mode-select high reset the controller and release any high-z hold on the memory.
// - the three-bit instruction register holds the identification read after power-up and in reset.
// - on instruction capture the two low instruction bits load the pattern 01.
package sbt_pkg;

   localparam int IR_W = 3;
   localparam int BSR_W = 107;
   localparam int ID_W = 32;

   // instruction codes
   localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
   localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
   localparam logic [IR_W-1:0] INS_SAMPLEZ = 3'h2;
   localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
   localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

   localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
   localparam logic [IR_W-1:0] IR_RESET_VAL = INS_IDCODE;
   localparam logic [ID_W-1:0] ID_CODE_VAL = 32'h0000_0001; // arbitrary value
   localparam logic BYP_CAPTURE_VAL = 1'b0;
   localparam int TMS_RESET_EDGES = 5;

   typedef enum logic [3:0] {
      ST_TLR, ST_IDLE, ST_SELDR, ST_CAPDR, ST_SHDR, ST_EX1DR, ST_PAUDR, ST_EX2DR,
      ST_UPDR, ST_SELIR, ST_CAPIR, ST_SHIR, ST_EX1IR, ST_PAUIR, ST_EX2IR, ST_UPIR
   } sbt_state_e;

   typedef enum logic [1:0] {
      SEL_BSR, SEL_ID, SEL_BYP
   } sbt_sel_e;

   // pad side of the test pins; en low means the pin is not driven
   typedef struct packed {
      logic tms;
      logic tms_en;
      logic tdi;
      logic tdi_en;
   } sbt_pins_s;

endpackage : sbt_pkg

/* sbt_jtag_host.sv */
`timescale 1ns/100ps
`default_nettype none
module sbt_jtag_host (
   // test link
   output logic o_tck,
   output var sbt_pkg::sbt_pins_s o_tap,
   input wire logic i_tdo,
   input wire logic i_tdo_oe
);
   initial begin
      o_tck = 1'h0;
      o_tap = '{tms: 1'h1, tms_en: 1'h0, tdi: 1'h0, tdi_en: 1'h0};
   end
   // one tck; pins change while tck is low, q is what tdo shows before the rise
   task automatic bit_io(input logic tms, input logic tdi, input logic drv, output logic q);
      q = i_tdo;
      // undriven pins carry junk, so only the pull-up can give a one
      o_tap = '{tms: drv ? tms : ~o_tap.tms, tms_en: drv,
                tdi: drv ? tdi : ~o_tap.tdi, tdi_en: drv};
      #20 o_tck = 1'h1;
      #40 o_tck = 1'h0;
      #20;
   endtask : bit_io
   task automatic walk(input logic [7:0] tms, input int n);
      logic q;
      for (int i = 0; i < n; i++) bit_io(tms[i], 1'h0, 1'h1, q);
   endtask : walk
   // from idle: capture, shift len bits lsb first, update, back to idle
   task automatic scan(input logic ir, input logic [127:0] din, input int len,
                       output logic [127:0] dout, output logic oe);
      logic q;
      dout = '0;
      walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
      oe = i_tdo_oe;
      for (int i = 0; i < len; i++) begin
         bit_io(i == len - 1, din[i], 1'h1, q);
         dout[i] = q;
      end
      walk(8'h01, 2);
   endtask : scan
endmodule : sbt_jtag_host
`default_nettype wire

/* sbt_tap_front_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module sbt_tap_front_tb;
   typedef struct {logic [2:0] ins; int w; logic hiz;} sbt_row_s;
   localparam logic [106:0] RING = {11'h5A3, 96'hC3A5_0F1E_9D24_7B86_E1F0_3C59};
   localparam logic [127:0] DIN = 128'h5A3C_96E1_0F87_D24B_39C6_A51E_7B04_E2D9;
   logic clk_sys = 1'h0;
   logic rst, ce, tck, tdo, tdo_oe, hiz, oe, q;
   logic [106:0] ring;
   logic [127:0] dout;
   sbt_pkg::sbt_pins_s tap;
   int n_errors = 0;
   int checks = 0;
   sbt_row_s rows [8] = '{'{3'h1, 32, 1'h0}, '{3'h7, 1, 1'h0}, '{3'h0, 107, 1'h0},
      '{3'h2, 107, 1'h1}, '{3'h4, 107, 1'h0}, '{3'h3, 1, 1'h0}, '{3'h5, 1, 1'h0},
      '{3'h6, 1, 1'h0}};
   sbt_tap_front dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_ce(ce), .i_ring(ring),
      .o_mem_hiz(hiz), .i_tck_link(tck), .i_tap(tap), .o_tdo(tdo), .o_tdo_oe(tdo_oe));
   sbt_jtag_host host (.o_tck(tck), .o_tap(tap), .i_tdo(tdo), .i_tdo_oe(tdo_oe));
   task automatic check(input logic [127:0] got, input logic [127:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   // captured value sits below the shifted-in bits, all cut to the scan length
   function automatic logic [127:0] expect_dr(input sbt_row_s r);
      logic [127:0] cap;
      cap = (r.ins == 3'h1) ? 128'(sbt_pkg::ID_CODE_VAL) :
            (r.ins inside {3'h0, 3'h2, 3'h4}) ? 128'(RING) : 128'h0;
      return (cap | (DIN << r.w)) & ((128'h1 << (r.w + 8)) - 128'h1);
   endfunction : expect_dr
   task automatic end_sim;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      #2000000;
      n_errors++;
      end_sim();
   end
   initial begin
      rst = 1'h1;
      ce = 1'h1;
      ring = RING;
      // test clock parked low through reset, as on a board that leaves the port unused
      repeat (10) @(negedge clk_sys);
      check(hiz, 1'h0);
      check(tdo_oe, 1'h0);
      rst = 1'h0;
      host.walk(8'h7F, 8);
      check(hiz, 1'h0);
      check(tdo_oe, 1'h0);
      for (int i = 0; i < 8; i++) begin
         host.scan(1'h1, {125'h0, rows[i].ins}, 3, dout, oe);
         check(dout[1:0], 2'h1);
         check(oe, 1'h1);
         host.scan(1'h0, DIN, rows[i].w + 8, dout, oe);
         check(dout, expect_dr(rows[i]));
         check(hiz, rows[i].hiz);
         check(tdo_oe, 1'h0);
      end
      // pins left floating must still reset the controller
      host.scan(1'h1, 128'h2, 3, dout, oe);
      repeat (5) @(negedge clk_sys);
      check(hiz, 1'h1);
      for (int i = 0; i < 5; i++) host.bit_io(1'h0, 1'h0, 1'h0, q);
      host.walk(8'h00, 1);
      repeat (5) @(negedge clk_sys);
      check(hiz, 1'h0);
      host.scan(1'h0, DIN, 40, dout, oe);
      check(dout, expect_dr(rows[0]));
      // clock enable low: a whole instruction load must be ignored
      @(negedge clk_sys) ce = 1'h0;
      host.walk(8'h00, 2);
      host.scan(1'h1, 128'h7, 3, dout, oe);
      check(oe, 1'h0);
      @(negedge clk_sys) ce = 1'h1;
      host.walk(8'h00, 2);
      host.scan(1'h0, DIN, 40, dout, oe);
      check(dout, expect_dr(rows[0]));
      end_sim();
   end
endmodule : sbt_tap_front_tb
`default_nettype wire
